// ===== usb_ep_dma_stall_ctrl.sv
// Endpoint 1 receive DMA request and endpoint stall register block
// Functional notes
// - Bit 0 of the DMA enable register is read/write, resets to zero and enables endpoint 1 receive DMA.
// - The DMA start request is high while the enable is set and the receive FIFO holds a byte.
// - When DMA has drained all received data, endpoint 1 is treated as read and completion fires.
// - Enabling DMA never masks endpoint 1 interrupts; only the enable register gates them.
// - A set stall bit makes the endpoint answer host transactions with STALL.
// - Receiving an 8-byte setup command clears the endpoint 0 stall bit.
// - While the setup-received flag is 1, writes of 1 to the endpoint 0 stall bit are ignored.
// - Stall bits for endpoints 3 to 0 sit at bits 3 to 0, read/write, resetting to 0.
// - Stall register bits 7 to 4 read as 0 and writes to them have no effect.
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_defines.svh"
module usb_ep_dma_stall_ctrl (
	input wire logic mclk,
	input wire logic reset,
	input wire usb_ep_pkg::reg_req_type req,
	output logic [7:0] rdata,
	input wire logic ep1_fifo_nonempty,
	input wire logic ep1_dma_read,
	input wire logic ep1_cpu_read_done,
	input wire logic setup_start,
	input wire logic setup_byte,
	input wire usb_ep_pkg::token_type token,
	output logic endpoint1_dma_start_request,
	output logic ep1_read_complete,
	output logic stall_answer,
	output logic irq
);
	typedef struct packed {
		logic [7:0] rdata;
		logic dma_en;
		logic [`STALL_FIELD_MSB:0] stall;
		logic setup_flag;
		logic [`IRQ_WIDTH-1:0] irq_status;
		logic [`IRQ_WIDTH-1:0] irq_enable;
		logic dreq;
		logic rd_complete;
		logic irq;
		logic drained_pending;
	} ctrl_state_type;
	ctrl_state_type s_q, s_d;
	logic setup_complete;
	logic stall_ans_int;
	logic [`IRQ_WIDTH-1:0] ev;
	// ==========================================
	// Submodules
	usb_ep_setup_detect u_setup (
		.mclk(mclk),
		.reset(reset),
		.setup_start(setup_start),
		.setup_byte(setup_byte),
		.setup_complete(setup_complete)
	);
	usb_ep_stall_responder u_stall (
		.mclk(mclk),
		.reset(reset),
		.token(token),
		.stall_bits(s_q.stall),
		.stall_answer(stall_ans_int)
	);
	// ==========================================
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.rdata = `RESET_BYTE;
		s_d.rd_complete = 1'b0;
		ev = '0;
		// Register writes
		if (req.wr) begin
			if (req.addr == `ADDR_DMA_ENABLE) begin
				s_d.dma_en = req.wdata[`BIT_EP1_DMA_ENABLE];
			end else if (req.addr == `ADDR_STALL) begin
				s_d.stall[`STALL_FIELD_MSB:1] = req.wdata[`STALL_FIELD_MSB:1];
				if (!(s_q.setup_flag && req.wdata[0])) begin
					s_d.stall[0] = req.wdata[0];
				end
			end else if (req.addr == `ADDR_IRQ_ENABLE) begin
				s_d.irq_enable = req.wdata[`IRQ_WIDTH-1:0];
			end else if (req.addr == `ADDR_IRQ_CLEAR) begin
				s_d.irq_status = s_q.irq_status & ~req.wdata[`IRQ_WIDTH-1:0];
			end else if (req.addr == `ADDR_SETUP_FLAG) begin
				if (req.wdata[0] == 1'b0) begin
					s_d.setup_flag = 1'b0;
				end
			end
		end
		// Setup reception clears endpoint 0 stall and raises the flag
		if (setup_complete) begin
			s_d.stall[0] = 1'b0;
			s_d.setup_flag = 1'b1;
			ev[`IRQ_BIT_SETUP] = 1'b1;
		end
		// DMA request
		s_d.dreq = s_d.dma_en && ep1_fifo_nonempty;
		// Drain completion
		if (s_q.dma_en && ep1_dma_read) begin
			s_d.drained_pending = 1'b1;
		end
		if (s_q.drained_pending && !ep1_fifo_nonempty) begin
			s_d.drained_pending = 1'b0;
			s_d.rd_complete = 1'b1;
			ev[`IRQ_BIT_DMA_DONE] = 1'b1;
		end
		if (ep1_cpu_read_done) begin
			s_d.rd_complete = 1'b1;
		end
		if (stall_ans_int) begin
			ev[`IRQ_BIT_STALL_SENT] = 1'b1;
		end
		// Sticky status, set wins over clear
		s_d.irq_status = s_d.irq_status | ev;
		s_d.irq = |(s_d.irq_status & s_d.irq_enable);
		// Register reads
		if (req.rd) begin
			if (req.addr == `ADDR_DMA_ENABLE) begin
				s_d.rdata = {7'h00, s_q.dma_en};
			end else if (req.addr == `ADDR_STALL) begin
				s_d.rdata = {`STALL_RESERVED_ZERO, s_q.stall};
			end else if (req.addr == `ADDR_IRQ_STATUS) begin
				s_d.rdata = {5'h00, s_q.irq_status};
			end else if (req.addr == `ADDR_IRQ_ENABLE) begin
				s_d.rdata = {5'h00, s_q.irq_enable};
			end else if (req.addr == `ADDR_SETUP_FLAG) begin
				s_d.rdata = {7'h00, s_q.setup_flag};
			end else begin
				s_d.rdata = `RESET_BYTE;
			end
		end
	end
	// ==========================================
	// State register
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	// ==========================================
	// Outputs
	logic stall_ans_q;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			stall_ans_q <= 1'b0;
		end else begin
			stall_ans_q <= stall_ans_int;
		end
	end
	assign rdata = s_q.rdata;
	assign endpoint1_dma_start_request = s_q.dreq;
	assign ep1_read_complete = s_q.rd_complete;
	assign stall_answer = stall_ans_q;
	assign irq = s_q.irq;
endmodule
`default_nettype wire

// ===== usb_ep_defines.svh
// Register offsets, field positions and reset values of the endpoint DMA and stall block
`ifndef USB_EP_DEFINES_SVH
`define USB_EP_DEFINES_SVH
`define ADDR_DMA_ENABLE 4'h0
`define ADDR_STALL 4'h1
`define ADDR_IRQ_STATUS 4'h2
`define ADDR_IRQ_ENABLE 4'h3
`define ADDR_IRQ_CLEAR 4'h4
`define ADDR_SETUP_FLAG 4'h5
`define BIT_EP1_DMA_ENABLE 0
`define STALL_FIELD_MSB 3
`define STALL_RESERVED_ZERO 4'h0
`define RESET_BYTE 8'h00
`define RESET_STALL 4'h0
`define IRQ_BIT_DMA_DONE 0
`define IRQ_BIT_SETUP 1
`define IRQ_BIT_STALL_SENT 2
`define IRQ_WIDTH 3
`define SETUP_LEN 4'h8
`endif

// ===== usb_ep_pkg.sv
// Types shared by the endpoint DMA and stall block
package usb_ep_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_type;
	typedef struct packed {
		logic [3:0] token_ep;
		logic token_valid;
	} token_type;
	typedef enum logic [1:0] {
		SETUP_IDLE = 2'b00,
		SETUP_COUNT = 2'b01,
		SETUP_DONE = 2'b10
	} setup_state_type;
endpackage

// ===== usb_ep_setup_detect.sv
// Counts the bytes of a setup command and flags a complete 8-byte command
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_defines.svh"
module usb_ep_setup_detect (
	input wire logic mclk,
	input wire logic reset,
	input wire logic setup_start,
	input wire logic setup_byte,
	output logic setup_complete
);
	typedef struct packed {
		usb_ep_pkg::setup_state_type st;
		logic [3:0] cnt;
		logic done;
	} sd_state_type;
	sd_state_type s_q, s_d;
	// ==========================================
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		case (s_q.st)
			usb_ep_pkg::SETUP_IDLE: begin
				if (setup_start) begin
					s_d.st = usb_ep_pkg::SETUP_COUNT;
					s_d.cnt = 4'h0;
				end
			end
			usb_ep_pkg::SETUP_COUNT: begin
				if (setup_start) begin
					s_d.cnt = 4'h0;
				end else if (setup_byte) begin
					s_d.cnt = s_q.cnt + 4'h1;
					if (s_q.cnt + 4'h1 == `SETUP_LEN) begin
						s_d.st = usb_ep_pkg::SETUP_DONE;
					end
				end
			end
			usb_ep_pkg::SETUP_DONE: begin
				s_d.done = 1'b1;
				s_d.st = usb_ep_pkg::SETUP_IDLE;
			end
			default: begin
				s_d.st = usb_ep_pkg::SETUP_IDLE;
			end
		endcase
	end
	// ==========================================
	// State register
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign setup_complete = s_q.done;
endmodule
`default_nettype wire

// ===== usb_ep_stall_responder.sv
// Decides the stall handshake for a token addressed to endpoints 0 to 3
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_defines.svh"
module usb_ep_stall_responder (
	input wire logic mclk,
	input wire logic reset,
	input wire usb_ep_pkg::token_type token,
	input wire logic [`STALL_FIELD_MSB:0] stall_bits,
	output logic stall_answer
);
	typedef struct packed {
		logic ans;
	} sr_state_type;
	sr_state_type s_q, s_d;
	// ==========================================
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.ans = 1'b0;
		if (token.token_valid && (token.token_ep <= 4'(`STALL_FIELD_MSB))) begin
			s_d.ans = stall_bits[token.token_ep[1:0]];
		end
	end
	// ==========================================
	// State register
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign stall_answer = s_q.ans;
endmodule
`default_nettype wire

// ===== usb_ep_dma_stall_ctrl_asserts.sv
// Port checks of the endpoint DMA and stall block
`timescale 1ns/1ps
`default_nettype none
module usb_ep_dma_stall_ctrl_asserts (
	input wire logic mclk,
	input wire logic reset,
	input wire usb_ep_pkg::reg_req_type req,
	input wire logic [7:0] rdata,
	input wire logic ep1_fifo_nonempty,
	input wire logic ep1_cpu_read_done,
	input wire usb_ep_pkg::token_type token,
	input wire logic endpoint1_dma_start_request,
	input wire logic ep1_read_complete,
	input wire logic stall_answer,
	input wire logic irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	sequence s_rd_stall; req.rd && req.addr == 4'h1; endsequence
	sequence s_en_on;
		req.wr && req.addr == 4'h0 && req.wdata[0] && ep1_fifo_nonempty;
	endsequence
	a_stall_rsvd_zero: assert property (s_rd_stall |=> rdata[7:4] == 4'h0)
		else $error("stall upper bits set");
	a_stall_from_token: assert property (stall_answer |->
		$past(token.token_valid, 2) && $past(token.token_ep, 2) <= 4'h3)
		else $error("stall without token");
	a_dma_req_on: assert property (s_en_on ##1 ep1_fifo_nonempty
		|-> endpoint1_dma_start_request)
		else $error("request missing");
	a_dma_req_off: assert property (req.wr && req.addr == 4'h0 && !req.wdata[0]
		|=> !endpoint1_dma_start_request)
		else $error("request after disable");
	a_req_fifo_empty: assert property (!ep1_fifo_nonempty |=> !endpoint1_dma_start_request)
		else $error("request while empty");
	a_done_when_empty: assert property (ep1_read_complete && !$past(ep1_cpu_read_done)
		|-> $past(!ep1_fifo_nonempty))
		else $error("completion with data left");
	a_done_one_pulse: assert property (ep1_read_complete && !ep1_cpu_read_done
		|=> !ep1_read_complete)
		else $error("completion too long");
	a_irq_gate_off: assert property (req.wr && req.addr == 4'h3 && req.wdata == 8'h00
		|=> !irq)
		else $error("irq while disabled");
endmodule
bind usb_ep_dma_stall_ctrl usb_ep_dma_stall_ctrl_asserts i_asserts (.mclk(mclk), .reset(reset),
	.req(req), .rdata(rdata), .ep1_fifo_nonempty(ep1_fifo_nonempty),
	.ep1_cpu_read_done(ep1_cpu_read_done), .token(token),
	.endpoint1_dma_start_request(endpoint1_dma_start_request),
	.ep1_read_complete(ep1_read_complete), .stall_answer(stall_answer), .irq(irq));
`default_nettype wire

// ===== usb_ep_far_model.sv
// Receive FIFO and DMA controller model on the application side
`timescale 1ns/1ps
`default_nettype none
module usb_ep_far_model (
	input wire logic mclk,
	input wire logic reset,
	input wire logic request,
	input wire logic load,
	input wire logic [7:0] fill,
	output logic fifo_nonempty,
	output logic dma_read
);
	logic [7:0] count_q;
	logic gap_q;
	assign fifo_nonempty = count_q != 8'h00;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			count_q <= 8'h00;
			gap_q <= 1'b0;
			dma_read <= 1'b0;
		end else begin
			gap_q <= !gap_q;
			dma_read <= request && fifo_nonempty && gap_q && !dma_read;
			if (load) begin
				count_q <= fill;
			end else if (dma_read) begin
				count_q <= count_q - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ===== usb_endpoint_dma_and_stall_ctrl_tb.sv
// Self-checking bench of the endpoint DMA and stall block
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_dma_and_stall_ctrl_tb;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	usb_ep_pkg::reg_req_type req = '0;
	usb_ep_pkg::token_type token = '0;
	logic [7:0] fill = 8'h00;
	logic load = 1'b0;
	logic setup_start = 1'b0;
	logic setup_byte = 1'b0;
	logic cpu_done = 1'b0;
	logic [7:0] rdata;
	logic nonempty, dma_read, request, done, stall, irq;
	int failures = 0;
	int total_checks = 0;
	always #50 mclk = ~mclk;
	usb_ep_dma_stall_ctrl i_usb_ep_dma_stall_ctrl (.mclk(mclk), .reset(reset), .req(req),
		.rdata(rdata), .ep1_fifo_nonempty(nonempty), .ep1_dma_read(dma_read),
		.ep1_cpu_read_done(cpu_done), .setup_start(setup_start), .setup_byte(setup_byte),
		.token(token), .endpoint1_dma_start_request(request), .ep1_read_complete(done),
		.stall_answer(stall), .irq(irq));
	usb_ep_far_model i_usb_ep_far_model (.mclk(mclk), .reset(reset), .request(request),
		.load(load), .fill(fill), .fifo_nonempty(nonempty), .dma_read(dma_read));
	task check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk) req <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk) req.wr <= 1'b0;
	endtask
	task rdchk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk) req.rd <= 1'b0;
		@(negedge mclk) check(rdata, exp);
	endtask
	task tok(input logic [3:0] ep, input logic exp);
		logic seen;
		seen = 1'b0;
		@(posedge mclk) token <= '{ep, 1'b1};
		@(posedge mclk) token.token_valid <= 1'b0;
		repeat (3) @(negedge mclk) seen = seen | stall;
		check({7'h00, seen}, {7'h00, exp});
	endtask
	task test_stall;
		rdchk(4'h1, 8'h00);
		wr(4'h1, 8'hFF);
		rdchk(4'h1, 8'h0F);
		tok(4'h1, 1'b1);
		tok(4'h5, 1'b0);
		wr(4'h1, 8'h00);
		tok(4'h1, 1'b0);
		$display("test_stall done");
	endtask
	task test_setup;
		wr(4'h1, 8'h01);
		@(posedge mclk) setup_start <= 1'b1;
		@(posedge mclk) setup_start <= 1'b0;
		repeat (8) begin
			@(posedge mclk) setup_byte <= 1'b1;
			@(posedge mclk) setup_byte <= 1'b0;
		end
		repeat (4) @(posedge mclk);
		rdchk(4'h1, 8'h00);
		wr(4'h1, 8'h01);
		rdchk(4'h1, 8'h00);
		wr(4'h5, 8'h00);
		wr(4'h1, 8'h01);
		rdchk(4'h1, 8'h01);
		$display("test_setup done");
	endtask
	task test_dma;
		int n;
		logic seen;
		rdchk(4'h0, 8'h00);
		wr(4'h4, 8'h07);
		wr(4'h3, 8'h01);
		wr(4'h0, 8'h01);
		rdchk(4'h0, 8'h01);
		@(posedge mclk) fill <= 8'h03;
		load <= 1'b1;
		@(posedge mclk) load <= 1'b0;
		n = 0;
		seen = 1'b0;
		while (done !== 1'b1 && n < 100) begin
			@(negedge mclk) seen = seen | request;
			n++;
		end
		check({7'h00, done}, 8'h01);
		check({7'h00, seen}, 8'h01);
		check({7'h00, request}, 8'h00);
		check({7'h00, irq}, 8'h01);
		rdchk(4'h2, 8'h01);
		wr(4'h4, 8'h01);
		repeat (2) @(negedge mclk);
		check({7'h00, irq}, 8'h00);
		@(posedge mclk) cpu_done <= 1'b1;
		@(posedge mclk) cpu_done <= 1'b0;
		@(negedge mclk) check({7'h00, done}, 8'h01);
		@(negedge mclk) check({7'h00, done}, 8'h00);
		$display("test_dma done");
	endtask
	task finish_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		failures++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		test_stall();
		test_setup();
		test_dma();
		finish_test();
	end
endmodule
`default_nettype wire
